// file: scss_pkg.sv
`default_nettype none

package scss_pkg;

  // ==================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CTRL_PERIOD_US = 1000;
  localparam int CTRL_CYCLES = CTRL_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int CTRL_TICKS_PER_S = 1000000 / CTRL_PERIOD_US;
  localparam int RPM_PER_RPS = 60;
  localparam int CENTI_PER_VOLT = 100;

  // ==================================================
  // Converter scaling, raw code to 0.01 V
  localparam int ADC_MID = 32768;
  localparam int ADC_NUM = 1000;
  localparam int ADC_SHIFT = 15;

  // ==================================================
  // Register offsets
  localparam logic [31:0] OFS_PRESET [8] = '{
    32'h20200520, 32'h20200620, 32'h20200720, 32'h20200820,
    32'h20201420, 32'h20201520, 32'h20201620, 32'h20201720};
  localparam logic [31:0] OFS_RAW_CH1 = 32'h25010610;
  localparam logic [31:0] OFS_RAW_CH2 = 32'h25010710;
  localparam logic [31:0] OFS_FILT_CH1 = 32'h25020110;
  localparam logic [31:0] OFS_FILT_CH2 = 32'h25020410;
  localparam logic [31:0] OFS_SRC_SEL = 32'h25020708;
  localparam logic [31:0] OFS_SCALE = 32'h25020a10;
  localparam logic [31:0] OFS_UPPER_CLIP = 32'h25020d10;
  localparam logic [31:0] OFS_LOWER_CLIP = 32'h25020e10;
  localparam logic [31:0] OFS_COND_CH1 = 32'h25020f10;
  localparam logic [31:0] OFS_COND_CH2 = 32'h25021010;
  localparam logic [31:0] OFS_DEAD_CH1 = 32'h2ff01d10;
  localparam logic [31:0] OFS_OFFS_CH1 = 32'h2ff01e10;
  localparam logic [31:0] OFS_DEAD_CH2 = 32'h2ff01f10;
  localparam logic [31:0] OFS_OFFS_CH2 = 32'h2ff02010;
  localparam logic [31:0] OFS_CMD_WORD = 32'h60400010;
  localparam logic [31:0] OFS_OP_MODE = 32'h60600008;
  localparam logic [31:0] OFS_RAMP_UP = 32'h60830020;
  localparam logic [31:0] OFS_RAMP_DN = 32'h60840020;
  localparam logic [31:0] OFS_TARGET = 32'h60ff0020;
  localparam logic [31:0] OFS_IDX_ASSIGN = 32'h2f000008;

  // ==================================================
  // Reset values and codes
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [31:0] RST_RAMP_RATE = 32'h00000064;
  localparam logic [15:0] RST_CLIP = 16'h0000;
  localparam logic [7:0] OP_MODE_PROFILE = 8'h03;
  localparam logic [7:0] OP_MODE_DIRECT = 8'hfd;
  localparam logic [15:0] CMD_ENABLE_MASK = 16'h000f;

  typedef enum logic [1:0] {
    SRC_PARAM = 2'b00,
    SRC_ANALOG_INPUT_ONE = 2'b01,
    SRC_ANALOG_INPUT_TWO = 2'b10
  } scss_src_t;

  // ==================================================
  // Shared arithmetic
  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07fff)
      return 16'sh7fff;
    else if (v < 18'sh38000)
      return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic signed [31:0] sat32(input logic signed [32:0] v);
    if (v > 33'sh07fffffff)
      return 32'sh7fffffff;
    else if (v < 33'sh180000000)
      return 32'sh80000000;
    return v[31:0];
  endfunction

  function automatic logic [3:0] bit_len(input logic [15:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 15; i++)
      if (v[i])
        n = 4'(i + 1);
    if (v[15])
      n = 4'hf;
    return n;
  endfunction

  function automatic logic [31:0] ramp_step(input logic [31:0] rate);
    logic [39:0] p;
    p = (40'(rate) * 40'(RPM_PER_RPS)) / 40'(CTRL_TICKS_PER_S);
    if (rate == 32'h0)
      return 32'h0;
    if (p == 40'h0)
      return 32'h1;
    return p[31:0];
  endfunction

endpackage

`default_nettype wire

// file: scss_ain_chan.sv
`timescale 1ns/100ps
`default_nettype none

module scss_ain_chan
  #(
    parameter int ADC_MID = scss_pkg::ADC_MID,
    parameter int ADC_NUM = scss_pkg::ADC_NUM,
    parameter int ADC_SHIFT = scss_pkg::ADC_SHIFT
  )
  (
    // Clock, reset, control tick
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic tick_i,
    // Raw sample and settings
    input wire logic [15:0] raw_i,
    input wire logic [15:0] filt_ms_i,
    input wire logic signed [15:0] offset_i,
    input wire logic signed [15:0] dead_i,
    // Conditioned results, 0.01 V
    output logic signed [15:0] corr_o,
    output logic signed [15:0] value_o
  );
  import scss_pkg::*;

  // ==================================================
  // Filter, offset, deadband
  logic signed [16:0] raw_diff;
  logic signed [31:0] centi;
  logic signed [31:0] acc_r;
  logic signed [31:0] acc_nxt;
  logic signed [15:0] corr_nxt;
  logic signed [15:0] value_nxt;
  logic [16:0] dmag;
  logic [16:0] cmag;

  assign raw_diff = $signed({1'b0, raw_i}) - $signed(17'(ADC_MID));
  assign centi = (32'(raw_diff) * 32'(ADC_NUM)) >>> ADC_SHIFT;

  // Shift filter: time constant is next power of two above the setting, at most 2^15 for settings of 16384 and up
  assign acc_nxt = acc_r + (((centi <<< 16) - acc_r) >>> bit_len(filt_ms_i));
  assign corr_nxt = sat16(18'(acc_nxt >>> 16) - 18'(offset_i));

  always_comb
  begin
    dmag = dead_i[15] ? 17'(-18'(dead_i)) : 17'(dead_i);
    cmag = corr_nxt[15] ? 17'(-18'(corr_nxt)) : 17'(corr_nxt);
    if (cmag <= dmag)
      value_nxt = 16'sh0000;
    else if (corr_nxt > 16'sh0000)
      value_nxt = sat16(18'(corr_nxt) - 18'($signed({1'b0, dmag})));
    else
      value_nxt = sat16(18'(corr_nxt) + 18'($signed({1'b0, dmag})));
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      acc_r <= 32'sh0;
      corr_o <= 16'sh0;
      value_o <= 16'sh0;
    end
    else if (tick_i)
    begin
      acc_r <= acc_nxt;
      corr_o <= corr_nxt;
      value_o <= value_nxt;
    end
  end

  chk_offset_sub: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick_i |=> corr_o == sat16(18'(acc_r >>> 16) - 18'($past(offset_i))))
    else $error("corrected value does not match filter minus offset");

  chk_dead_zone: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick_i |=> !((corr_o <= $past(dead_i)) && (corr_o >= -$past(dead_i))
      && !$past(dead_i[15])) || (value_o == 16'sh0000))
    else $error("value inside deadband is not zero");

endmodule

`default_nettype wire

// file: scss_speed_select.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// - Per-channel filter time, deadband, offset settings
// - Filtered input minus offset forms corrected value
// - Deadband zeroes small values, shrinks larger ones
// - Nonzero upper threshold zeroes values above it
// - Nonzero lower threshold zeroes values below it
// - Selector picks target parameter, channel one, two
// - Analog target is value times speed factor
// - Raw converter readings readable as unsigned words
// - Preset mode picks one of eight speeds
// - Index lines form bits; unassigned read zero
// - Active index input counts as logic one
// - Preset mode needs an assigned index line
// - Preset mode only in modes 3, -3
// - Mode 3 ramps with valid up/down rates
// - Mode -3 applies command directly, no ramp
module scss_speed_select
  #(
    parameter int unsigned CTRL_CYCLES_P = scss_pkg::CTRL_CYCLES
  )
  (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Analog converter samples
    input wire logic [15:0] analog_input_one_i,
    input wire logic [15:0] analog_input_two_i,
    // Preset index pins
    input wire logic preset_index_line_zero_i,
    input wire logic preset_index_line_one_i,
    input wire logic preset_index_line_two_i,
    // Speed results
    output logic signed [31:0] speed_target_o,
    output logic signed [31:0] speed_cmd_o,
    output logic din_mode_o,
    output logic drive_enabled_o,
    output logic ctrl_tick_o
  );
  import scss_pkg::*;

  // ==================================================
  // Registers
  logic signed [31:0] preset_r [8];
  logic [15:0] filt_ch1_r;
  logic [15:0] filt_ch2_r;
  logic [7:0] src_sel_r;
  logic signed [15:0] speed_scale_r;
  logic signed [15:0] upper_clip_r;
  logic signed [15:0] lower_clip_r;
  logic signed [15:0] dead_ch1_r;
  logic signed [15:0] offs_ch1_r;
  logic signed [15:0] dead_ch2_r;
  logic signed [15:0] offs_ch2_r;
  logic [15:0] cmd_word_r;
  logic [7:0] op_mode_r;
  logic [31:0] ramp_up_r;
  logic [31:0] ramp_dn_r;
  logic signed [31:0] target_speed_r;
  logic [2:0] idx_assign_r;

  // ==================================================
  // Internal state
  logic [31:0] tick_cnt_r;
  logic [2:0] idx_s1_r;
  logic [2:0] idx_s2_r;
  logic [2:0] idx_s3_r;
  logic [2:0] idx_line_r;
  logic signed [15:0] cond_ch1;
  logic signed [15:0] cond_ch2;
  logic signed [15:0] corr_ch1;
  logic signed [15:0] corr_ch2;
  logic [31:0] rd_mux;

  // ==================================================
  // Control cycle divider
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tick_cnt_r <= 32'h0;
      ctrl_tick_o <= 1'b0;
    end
    else
    begin
      ctrl_tick_o <= (tick_cnt_r == 32'(CTRL_CYCLES_P - 1));
      if (tick_cnt_r == 32'(CTRL_CYCLES_P - 1))
        tick_cnt_r <= 32'h0;
      else
        tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // ==================================================
  // Register writes
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < 8; i++)
        preset_r[i] <= RST_WORD;
    end
    else if (reg_wr_i)
    begin
      for (int i = 0; i < 8; i++)
        if (reg_addr_i == OFS_PRESET[i])
          preset_r[i] <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      filt_ch1_r <= RST_WORD[15:0];
      filt_ch2_r <= RST_WORD[15:0];
      src_sel_r <= RST_WORD[7:0];
      speed_scale_r <= RST_WORD[15:0];
      upper_clip_r <= RST_CLIP;
      lower_clip_r <= RST_CLIP;
      dead_ch1_r <= RST_WORD[15:0];
      offs_ch1_r <= RST_WORD[15:0];
      dead_ch2_r <= RST_WORD[15:0];
      offs_ch2_r <= RST_WORD[15:0];
      cmd_word_r <= RST_WORD[15:0];
      op_mode_r <= RST_WORD[7:0];
      ramp_up_r <= RST_RAMP_RATE;
      ramp_dn_r <= RST_RAMP_RATE;
      target_speed_r <= RST_WORD;
      idx_assign_r <= RST_WORD[2:0];
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == OFS_FILT_CH1)
        filt_ch1_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_FILT_CH2)
        filt_ch2_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_SRC_SEL)
        src_sel_r <= reg_wdata_i[7:0];
      else if (reg_addr_i == OFS_SCALE)
        speed_scale_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_UPPER_CLIP)
        upper_clip_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_LOWER_CLIP)
        lower_clip_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_DEAD_CH1)
        dead_ch1_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_OFFS_CH1)
        offs_ch1_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_DEAD_CH2)
        dead_ch2_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_OFFS_CH2)
        offs_ch2_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_CMD_WORD)
        cmd_word_r <= reg_wdata_i[15:0];
      else if (reg_addr_i == OFS_OP_MODE)
        op_mode_r <= reg_wdata_i[7:0];
      else if (reg_addr_i == OFS_RAMP_UP)
        ramp_up_r <= reg_wdata_i;
      else if (reg_addr_i == OFS_RAMP_DN)
        ramp_dn_r <= reg_wdata_i;
      else if (reg_addr_i == OFS_TARGET)
        target_speed_r <= reg_wdata_i;
      else if (reg_addr_i == OFS_IDX_ASSIGN)
        idx_assign_r <= reg_wdata_i[2:0];
    end
  end

  // ==================================================
  // Register reads, data only in the cycle after the strobe
  always_comb
  begin
    rd_mux = 32'h0;
    for (int i = 0; i < 8; i++)
      if (reg_addr_i == OFS_PRESET[i])
        rd_mux = preset_r[i];
    if (reg_addr_i == OFS_RAW_CH1)
      rd_mux = {16'h0, analog_input_one_i};
    else if (reg_addr_i == OFS_RAW_CH2)
      rd_mux = {16'h0, analog_input_two_i};
    else if (reg_addr_i == OFS_COND_CH1)
      rd_mux = {16'h0, cond_ch1};
    else if (reg_addr_i == OFS_COND_CH2)
      rd_mux = {16'h0, cond_ch2};
    else if (reg_addr_i == OFS_FILT_CH1)
      rd_mux = {16'h0, filt_ch1_r};
    else if (reg_addr_i == OFS_FILT_CH2)
      rd_mux = {16'h0, filt_ch2_r};
    else if (reg_addr_i == OFS_SRC_SEL)
      rd_mux = {24'h0, src_sel_r};
    else if (reg_addr_i == OFS_SCALE)
      rd_mux = {16'h0, speed_scale_r};
    else if (reg_addr_i == OFS_UPPER_CLIP)
      rd_mux = {16'h0, upper_clip_r};
    else if (reg_addr_i == OFS_LOWER_CLIP)
      rd_mux = {16'h0, lower_clip_r};
    else if (reg_addr_i == OFS_DEAD_CH1)
      rd_mux = {16'h0, dead_ch1_r};
    else if (reg_addr_i == OFS_OFFS_CH1)
      rd_mux = {16'h0, offs_ch1_r};
    else if (reg_addr_i == OFS_DEAD_CH2)
      rd_mux = {16'h0, dead_ch2_r};
    else if (reg_addr_i == OFS_OFFS_CH2)
      rd_mux = {16'h0, offs_ch2_r};
    else if (reg_addr_i == OFS_CMD_WORD)
      rd_mux = {16'h0, cmd_word_r};
    else if (reg_addr_i == OFS_OP_MODE)
      rd_mux = {24'h0, op_mode_r};
    else if (reg_addr_i == OFS_RAMP_UP)
      rd_mux = ramp_up_r;
    else if (reg_addr_i == OFS_RAMP_DN)
      rd_mux = ramp_dn_r;
    else if (reg_addr_i == OFS_TARGET)
      rd_mux = target_speed_r;
    else if (reg_addr_i == OFS_IDX_ASSIGN)
      rd_mux = {29'h0, idx_assign_r};
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h0;
    else
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
  end

  // ==================================================
  // Index pin synchroniser
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      idx_s1_r <= 3'h0;
      idx_s2_r <= 3'h0;
      idx_s3_r <= 3'h0;
      idx_line_r <= 3'h0;
    end
    else
    begin
      idx_s1_r <= {preset_index_line_two_i, preset_index_line_one_i,
        preset_index_line_zero_i};
      idx_s2_r <= idx_s1_r;
      idx_s3_r <= idx_s2_r;
      // A bit moves only when the second and third stages agree
      idx_line_r <= (idx_s2_r & ~(idx_s2_r ^ idx_s3_r))
        | (idx_line_r & (idx_s2_r ^ idx_s3_r));
    end
  end

  // ==================================================
  // Analog channels
  scss_ain_chan u_chan1 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(ctrl_tick_o),
    .raw_i(analog_input_one_i),
    .filt_ms_i(filt_ch1_r),
    .offset_i(offs_ch1_r),
    .dead_i(dead_ch1_r),
    .corr_o(corr_ch1),
    .value_o(cond_ch1)
  );

  scss_ain_chan u_chan2 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(ctrl_tick_o),
    .raw_i(analog_input_two_i),
    .filt_ms_i(filt_ch2_r),
    .offset_i(offs_ch2_r),
    .dead_i(dead_ch2_r),
    .corr_o(corr_ch2),
    .value_o(cond_ch2)
  );

  // ==================================================
  // Source selection
  scss_src_t src_w;
  logic [2:0] preset_idx;
  logic din_ok;
  logic mode_speed;
  logic signed [15:0] sel_val;
  logic clip_hit;
  logic signed [31:0] prod_w;
  logic signed [31:0] scaled_w;
  logic signed [31:0] preset_sel_w;
  logic signed [31:0] target_nxt;

  always_comb
  begin
    if (src_sel_r == 8'h01)
      src_w = SRC_ANALOG_INPUT_ONE;
    else if (src_sel_r == 8'h02)
      src_w = SRC_ANALOG_INPUT_TWO;
    else
      src_w = SRC_PARAM;
  end

  assign preset_idx = idx_line_r & idx_assign_r;
  assign preset_sel_w = preset_r[preset_idx];
  assign mode_speed = (op_mode_r == OP_MODE_PROFILE)
    || (op_mode_r == OP_MODE_DIRECT);
  // Preset mode is refused unless the analog channel is closed
  assign din_ok = (idx_assign_r != 3'h0) && mode_speed
    && (src_w == SRC_PARAM);
  assign sel_val = (src_w == SRC_ANALOG_INPUT_TWO) ? cond_ch2 : cond_ch1;
  assign clip_hit = ((upper_clip_r != 16'sh0) && (sel_val > upper_clip_r))
    || ((lower_clip_r != 16'sh0) && (sel_val < lower_clip_r));
  // 16x16 product divided by 100 cannot leave 32 bits
  assign prod_w = 32'(sel_val) * 32'(speed_scale_r);
  assign scaled_w = 32'(prod_w / CENTI_PER_VOLT);

  always_comb
  begin
    case (src_w)
      SRC_ANALOG_INPUT_ONE, SRC_ANALOG_INPUT_TWO:
        target_nxt = clip_hit ? 32'sh0 : scaled_w;
      default:
        target_nxt = din_ok ? preset_sel_w : target_speed_r;
    endcase
  end

  // ==================================================
  // Profile ramp
  logic signed [32:0] gap_w;
  logic signed [32:0] gap_mag;
  logic rising;
  logic [31:0] rate_w;
  logic [31:0] step_w;
  logic signed [31:0] ramp_nxt;

  always_comb
  begin
    gap_w = 33'(target_nxt) - 33'(speed_cmd_o);
    gap_mag = gap_w[32] ? -gap_w : gap_w;
    rising = (gap_w > 33'sh0);
    // Moving away from zero uses the up rate, toward zero the down rate
    if (rising)
      rate_w = (speed_cmd_o >= 32'sh0) ? ramp_up_r : ramp_dn_r;
    else
      rate_w = (speed_cmd_o <= 32'sh0) ? ramp_up_r : ramp_dn_r;
    step_w = ramp_step(rate_w);
    if (step_w == 32'h0)
      ramp_nxt = speed_cmd_o;
    else if (gap_mag <= $signed({1'b0, step_w}))
      ramp_nxt = target_nxt;
    else if (rising)
      ramp_nxt = sat32(33'(speed_cmd_o) + $signed({1'b0, step_w}));
    else
      ramp_nxt = sat32(33'(speed_cmd_o) - $signed({1'b0, step_w}));
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      drive_enabled_o <= 1'b0;
    else
      drive_enabled_o <= ((cmd_word_r & CMD_ENABLE_MASK) == CMD_ENABLE_MASK);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      speed_target_o <= 32'sh0;
      speed_cmd_o <= 32'sh0;
      din_mode_o <= 1'b0;
    end
    else if (ctrl_tick_o)
    begin
      speed_target_o <= target_nxt;
      din_mode_o <= din_ok;
      if (!drive_enabled_o)
        speed_cmd_o <= 32'sh0;
      else if (op_mode_r == OP_MODE_PROFILE)
        speed_cmd_o <= ramp_nxt;
      else
        speed_cmd_o <= target_nxt;
    end
  end

  // ==================================================
  // Checks
  chk_hold_between: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ctrl_tick_o |=> $stable(speed_target_o) && $stable(speed_cmd_o))
    else $error("speed results changed between control ticks");

  chk_param_source: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && src_w == SRC_PARAM && !din_ok
      |=> speed_target_o == $past(target_speed_r))
    else $error("target parameter not used with selector zero");

  chk_analog_scale: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && src_w != SRC_PARAM && !clip_hit
      |=> speed_target_o == $past(sel_val) * $past(speed_scale_r) / 100)
    else $error("analog target not value times factor");

  chk_upper_clip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && src_w != SRC_PARAM && upper_clip_r != 16'sh0
      && sel_val > upper_clip_r |=> speed_target_o == 32'sh0)
    else $error("value above upper threshold not zeroed");

  chk_lower_clip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && src_w != SRC_PARAM && lower_clip_r != 16'sh0
      && sel_val < lower_clip_r |=> speed_target_o == 32'sh0)
    else $error("value below lower threshold not zeroed");

  chk_preset_pick: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && din_ok |=> speed_target_o == $past(preset_sel_w))
    else $error("preset speed not taken in preset mode");

  chk_sync_agree: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    idx_s2_r == idx_s3_r |=> idx_line_r == $past(idx_s2_r))
    else $error("agreed index level not taken");

  chk_needs_assign: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && idx_assign_r == 3'h0 && src_w == SRC_PARAM
      |=> speed_target_o == $past(target_speed_r))
    else $error("preset mode active with no index line assigned");

  chk_mode_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && src_w == SRC_PARAM && !mode_speed
      |=> !din_mode_o && speed_target_o == $past(target_speed_r))
    else $error("preset mode honoured outside modes 3 and -3");

  chk_direct_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && drive_enabled_o && op_mode_r == OP_MODE_DIRECT
      |=> speed_cmd_o == speed_target_o)
    else $error("direct mode command not equal to target");

  chk_ramp_invalid: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_tick_o && drive_enabled_o && op_mode_r == OP_MODE_PROFILE
      && ramp_up_r == 32'h0 && ramp_dn_r == 32'h0 |=> $stable(speed_cmd_o))
    else $error("ramp ran with zero rates");

endmodule

`default_nettype wire

// file: scss_far_end.sv
`timescale 1ns/100ps
`default_nettype none

// ==========
// Analog reference and index switches
module scss_far_end
  (
    // Clock
    input wire logic clk_i,
    // Wanted levels
    input wire logic [15:0] code1_i,
    input wire logic [15:0] code2_i,
    input wire logic [2:0] idx_i,
    // Pins
    output logic [15:0] analog_input_one_o,
    output logic [15:0] analog_input_two_o,
    output logic [2:0] idx_o
  );
  // Codes and switches settle a cycle late, like a sampled source
  always_ff @(posedge clk_i)
  begin
    analog_input_one_o <= code1_i;
    analog_input_two_o <= code2_i;
    idx_o <= idx_i;
  end
endmodule

`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import scss_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [31:0] ad = 32'h0;
  logic [31:0] wd = 32'h0;
  logic ws = 1'b0;
  logic rs = 1'b0;
  logic [15:0] c1 = 16'h8000;
  logic [15:0] c2 = 16'h8000;
  logic [2:0] ix = 3'h0;
  logic [31:0] rd;
  logic [31:0] tgt;
  logic [31:0] cmd;
  logic [15:0] a1;
  logic [15:0] a2;
  logic [2:0] il;
  logic dm;
  logic tk;
  logic de;
  int n_errors = 0;
  int compares = 0;

  // ==========
  // Clock, parts
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  scss_far_end far (.clk_i(clk_i), .code1_i(c1), .code2_i(c2), .idx_i(ix),
    .analog_input_one_o(a1), .analog_input_two_o(a2), .idx_o(il));
  // Short control cycle keeps the run brief
  scss_speed_select #(.CTRL_CYCLES_P(8)) dut (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_wr_i(ws), .reg_rd_i(rs), .reg_rdata_o(rd),
    .analog_input_one_i(a1), .analog_input_two_i(a2),
    .preset_index_line_zero_i(il[0]), .preset_index_line_one_i(il[1]),
    .preset_index_line_two_i(il[2]), .speed_target_o(tgt),
    .speed_cmd_o(cmd), .din_mode_o(dm), .drive_enabled_o(de),
    .ctrl_tick_o(tk));

  // ==========
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    ad <= a;
    wd <= d;
    ws <= 1'b1;
    @(posedge clk_i);
    ws <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_i);
    ad <= a;
    rs <= 1'b1;
    @(posedge clk_i);
    rs <= 1'b0;
    #1;
    chk(rd, e);
  endtask
  // Results land at the edge after a tick
  task automatic tw(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      while (tk !== 1'b1)
        @(posedge clk_i);
    end
    @(posedge clk_i);
    #1;
  endtask
  task automatic results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========
  // Tests
  initial
  begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdc(OFS_UPPER_CLIP, 32'h0);
    rdc(OFS_LOWER_CLIP, 32'h0);
    rdc(OFS_RAMP_UP, 32'h64);
    rdc(32'h12345678, 32'h0);
    $display("test reset done");
    wr(OFS_IDX_ASSIGN, 32'h7);
    wr(OFS_OP_MODE, 32'hfd);
    wr(OFS_CMD_WORD, 32'hf);
    wr(OFS_SRC_SEL, 32'h0);
    wr(OFS_TARGET, 32'h1f4);
    for (int i = 0; i < 8; i++)
      wr(OFS_PRESET[i], 32'(i * 1000 - 3000));
    for (int i = 0; i < 8; i++)
    begin
      rdc(OFS_PRESET[i], 32'(i * 1000 - 3000));
      @(posedge clk_i) ix <= 3'(i);
      tw(2);
      chk(tgt, 32'(i * 1000 - 3000));
      chk(cmd, 32'(i * 1000 - 3000));
      chk({31'h0, dm}, 32'h1);
    end
    chk({31'h0, de}, 32'h1);
    wr(OFS_IDX_ASSIGN, 32'h1);
    tw(2);
    chk(tgt, 32'hfffff830);
    wr(OFS_IDX_ASSIGN, 32'h0);
    tw(2);
    chk({31'h0, dm}, 32'h0);
    chk(tgt, 32'h1f4);
    wr(OFS_IDX_ASSIGN, 32'h7);
    wr(OFS_OP_MODE, 32'h1);
    tw(2);
    chk({31'h0, dm}, 32'h0);
    $display("test presets done");
    // 5 V on channel one, offset 2 V, deadband 1 V, 100 rpm per volt
    wr(OFS_OP_MODE, 32'hfd);
    wr(OFS_IDX_ASSIGN, 32'h0);
    wr(OFS_OFFS_CH1, 32'hc8);
    wr(OFS_DEAD_CH1, 32'h64);
    wr(OFS_SCALE, 32'h64);
    wr(OFS_SRC_SEL, 32'h1);
    @(posedge clk_i) c1 <= 16'hc000;
    tw(4);
    chk(tgt, 32'hc8);
    rdc(OFS_COND_CH1, 32'hc8);
    rdc(OFS_RAW_CH1, 32'hc000);
    @(posedge clk_i) c1 <= 16'h4000;
    tw(4);
    chk(tgt, 32'hfffffda8);
    wr(OFS_LOWER_CLIP, 32'hfe0c);
    tw(4);
    chk(tgt, 32'h0);
    wr(OFS_LOWER_CLIP, 32'h0);
    @(posedge clk_i) c1 <= 16'hc000;
    wr(OFS_UPPER_CLIP, 32'h96);
    tw(4);
    chk(tgt, 32'h0);
    wr(OFS_UPPER_CLIP, 32'h0);
    wr(OFS_SRC_SEL, 32'h2);
    @(posedge clk_i) c2 <= 16'hc000;
    tw(4);
    chk(tgt, 32'h1f4);
    rdc(OFS_RAW_CH2, 32'hc000);
    // Shortest filter halves the gap once per control cycle
    wr(OFS_FILT_CH2, 32'h1);
    tw(1);
    @(posedge clk_i) c2 <= 16'h8000;
    tw(1);
    rdc(OFS_COND_CH2, 32'hfa);
    $display("test analog done");
    // Ramp of 100 rps/s gives 6 rpm per 1 ms step
    wr(OFS_SRC_SEL, 32'h0);
    wr(OFS_TARGET, 32'h0);
    tw(2);
    wr(OFS_OP_MODE, 32'h3);
    wr(OFS_TARGET, 32'h3c);
    tw(3);
    chk(cmd, 32'h12);
    tw(12);
    chk(cmd, 32'h3c);
    wr(OFS_RAMP_DN, 32'h0);
    wr(OFS_RAMP_UP, 32'h0);
    wr(OFS_TARGET, 32'h0);
    tw(3);
    chk(cmd, 32'h3c);
    wr(OFS_CMD_WORD, 32'h6);
    tw(2);
    chk(cmd, 32'h0);
    chk({31'h0, de}, 32'h0);
    $display("test ramp done");
    results();
  end

  initial
  begin
    #400000;
    n_errors++;
    results();
  end
endmodule

`default_nettype wire
